// ---- hdl/preamp_ctrl_regs.v ----
/*
  Control register bank and digital supervision of a triple-channel
  video pre-amp with overlay. Assumes all pins synchronous to i_mclk;
  analog path consumes the digital levels driven here.
*/
//
// Function
// - Seven-bit overall gain register for all channels, reset to 0x60.
// - Three seven-bit channel gains, blue, green, red, reset to 0x60.
// - Three eight-bit per-channel clamp levels, reset to 0x80.
// - One shared eight-bit brightness level, reset to 0x80.
// - Pedestal field bits 7-5 of shared byte, reset to four.
// - Overlay gain field bits 4-3 of shared byte, reset to two.
// - Level-shift field bits 2-0 of shared byte, reset to four.
// - Per-pixel source select between external video and overlay.
// - Overlay ignores brightness but keeps gain, level shift, overlay gain.
// - Overlay pixel clock locked to line blank, programmable divide ratio.
// - Lost vertical retrace: keep frame blank pulses, force black.
// - Lost horizontal retrace: force black, free-run line blank pulse.
// - Interlace tolerated: vertical phase may shift half a line per field.
// - Supply-low indication forces video outputs to reference level.
// - Active blanking added to outputs during every line blank.
// - Power control value one blanks video, value two enters save.
// - Fixed seven-bit slave address; write and read bytes differ in direction bit.
`timescale 1ns/1ns
`default_nettype none
`include "preamp_ctrl_consts.vh"
module preamp_ctrl_regs #(
  parameter LINE_TIMEOUT = `LINE_TIMEOUT,
  parameter FRAME_TIMEOUT = `FRAME_TIMEOUT,
  parameter FREE_LINE_PERIOD = `FREE_LINE_PERIOD
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // Serial host port
  input wire i_scl,
  input wire i_sda,
  output reg o_sda_out,
  output reg o_sda_oe,
  // Scan timing, supply level and overlay source select
  input wire i_line_retrace,
  input wire i_vertical_retrace_pulse,
  input wire i_supply_low_threshold,
  input wire i_overlay_source_select,
  // Timing outputs
  output reg o_line_blank_pulse,
  output reg o_frame_blank_pulse,
  output reg o_pixel_clk_en,
  // Analog settings
  output reg [6:0] o_blue_channel_gain,
  output reg [6:0] o_green_channel_gain,
  output reg [6:0] o_red_channel_gain,
  output reg [6:0] o_overall_gain,
  output reg [7:0] o_blue_clamp_level,
  output reg [7:0] o_green_clamp_level,
  output reg [7:0] o_red_clamp_level,
  output reg [7:0] o_brightness_level,
  output reg [2:0] o_pedestal,
  output reg [1:0] o_overlay_gain,
  output reg [2:0] o_video_level_shift,
  // Video path control
  output reg o_use_overlay,
  output reg o_brightness_apply,
  output reg o_force_black,
  output reg o_force_reference,
  output reg o_line_blank_pulse_insert,
  output reg o_power_save
);
  ////////////////////////////////////////////////////////////////
  // Serial slave and register file
  wire [15:0] bus_addr;
  wire [7:0] bus_wdata;
  wire bus_wr;
  wire slave_oe;
  reg [7:0] rdata;
  reg [6:0] gain_r [0:3];
  reg [7:0] clamp_r [0:3];
  reg [7:0] shared_r;
  reg [7:0] power_r;
  reg [7:0] pixdiv_r;
  reg line_lost_r;
  reg frame_lost_r;

  preamp_serial_slave u_slave (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_oe(slave_oe),
    .o_addr(bus_addr),
    .o_wdata(bus_wdata),
    .o_wr(bus_wr),
    .o_rd(),
    .i_rdata(rdata)
  );

  // Open-drain: drive low only
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sda_out <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      o_sda_out <= 1'b0;
      o_sda_oe <= slave_oe;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_regs
      always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          gain_r[gi] <= `RST_GAIN;
          clamp_r[gi] <= `RST_CLAMP;
        end else if (bus_wr) begin
          if (bus_addr == `OFS_BLUE_GAIN + gi) begin
            gain_r[gi] <= bus_wdata[6:0];
          end
          if (bus_addr == `OFS_BLUE_CLAMP + gi) begin
            clamp_r[gi] <= bus_wdata;
          end
        end
      end
    end
  endgenerate

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shared_r <= `RST_SHARED_CTRL;
      power_r <= `RST_POWER_CTRL;
      pixdiv_r <= `RST_PIXEL_DIV;
    end else if (bus_wr) begin
      if (bus_addr == `OFS_SHARED_CTRL) begin
        shared_r <= bus_wdata;
      end
      if (bus_addr == `OFS_POWER_CTRL) begin
        power_r <= bus_wdata;
      end
      if (bus_addr == `OFS_PIXEL_DIV) begin
        pixdiv_r <= (bus_wdata == 8'h00) ? 8'h01 : bus_wdata;
      end
    end
  end

  always @* begin
    case (bus_addr)
      `OFS_BLUE_GAIN: rdata = {1'b0, gain_r[0]};
      `OFS_GREEN_GAIN: rdata = {1'b0, gain_r[1]};
      `OFS_RED_GAIN: rdata = {1'b0, gain_r[2]};
      `OFS_OVERALL_GAIN: rdata = {1'b0, gain_r[3]};
      `OFS_BLUE_CLAMP: rdata = clamp_r[0];
      `OFS_GREEN_CLAMP: rdata = clamp_r[1];
      `OFS_RED_CLAMP: rdata = clamp_r[2];
      `OFS_BRIGHTNESS: rdata = clamp_r[3];
      `OFS_SHARED_CTRL: rdata = shared_r;
      `OFS_POWER_CTRL: rdata = power_r;
      `OFS_PIXEL_DIV: rdata = pixdiv_r;
      `OFS_STATUS: rdata = {5'h00, i_supply_low_threshold, frame_lost_r, line_lost_r};
      default: rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Line supervision and free-running line oscillator
  reg line_d_r;
  reg [15:0] line_wd_r;
  reg [15:0] free_cnt_r;
  wire line_rise;
  assign line_rise = i_line_retrace & ~line_d_r;

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      line_d_r <= 1'b0;
      line_wd_r <= 16'h0000;
      line_lost_r <= 1'b0;
      free_cnt_r <= 16'h0000;
    end else begin
      line_d_r <= i_line_retrace;
      if (line_rise) begin
        line_wd_r <= 16'h0000;
        line_lost_r <= 1'b0;
      end else if (line_wd_r >= LINE_TIMEOUT[15:0]) begin
        line_lost_r <= 1'b1;
      end else begin
        line_wd_r <= line_wd_r + 16'h0001;
      end
      if (line_rise || free_cnt_r >= FREE_LINE_PERIOD[15:0] - 16'h0001) begin
        free_cnt_r <= 16'h0000;
      end else begin
        free_cnt_r <= free_cnt_r + 16'h0001;
      end
    end
  end

  // Free-run pulse gated onto line blank when retrace is lost
  wire free_pulse;
  wire line_blank_c;
  assign free_pulse = (free_cnt_r < {4'h0, FREE_LINE_PERIOD[15:4]});
  assign line_blank_c = line_lost_r ? free_pulse : i_line_retrace;

  ////////////////////////////////////////////////////////////////
  // Frame supervision; watchdog counts time only, not line phase
  reg vert_d_r;
  reg [23:0] frame_wd_r;
  reg [23:0] frame_gen_r;
  wire vert_rise;
  assign vert_rise = i_vertical_retrace_pulse & ~vert_d_r;

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vert_d_r <= 1'b0;
      frame_wd_r <= 24'h00_0000;
      frame_gen_r <= 24'h00_0000;
      frame_lost_r <= 1'b0;
    end else begin
      vert_d_r <= i_vertical_retrace_pulse;
      if (vert_rise) begin
        frame_wd_r <= 24'h00_0000;
        frame_lost_r <= 1'b0;
      end else if (frame_wd_r >= FRAME_TIMEOUT[23:0]) begin
        frame_lost_r <= 1'b1;
      end else begin
        frame_wd_r <= frame_wd_r + 24'h00_0001;
      end
      if (!frame_lost_r || frame_gen_r >= FRAME_TIMEOUT[23:0]) begin
        frame_gen_r <= 24'h00_0000;
      end else begin
        frame_gen_r <= frame_gen_r + 24'h00_0001;
      end
    end
  end

  // Keep issuing frame blank from a local timer when retrace is lost
  wire frame_blank_c;
  assign frame_blank_c = frame_lost_r ? (frame_gen_r < {8'h00, FREE_LINE_PERIOD[15:0]}) :
                         i_vertical_retrace_pulse;

  ////////////////////////////////////////////////////////////////
  // Overlay pixel clock divider, restarted at each line blank
  reg [7:0] pix_cnt_r;
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pix_cnt_r <= 8'h00;
    end else if (line_blank_c || pix_cnt_r >= pixdiv_r - 8'h01) begin
      pix_cnt_r <= 8'h00;
    end else begin
      pix_cnt_r <= pix_cnt_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Output registers
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_line_blank_pulse <= 1'b0;
      o_frame_blank_pulse <= 1'b0;
      o_pixel_clk_en <= 1'b0;
      o_blue_channel_gain <= `RST_GAIN;
      o_green_channel_gain <= `RST_GAIN;
      o_red_channel_gain <= `RST_GAIN;
      o_overall_gain <= `RST_GAIN;
      o_blue_clamp_level <= `RST_CLAMP;
      o_green_clamp_level <= `RST_CLAMP;
      o_red_clamp_level <= `RST_CLAMP;
      o_brightness_level <= `RST_CLAMP;
      o_pedestal <= `RST_PEDESTAL;
      o_overlay_gain <= `RST_OVERLAY_GAIN;
      o_video_level_shift <= `RST_LEVEL_SHIFT;
      o_use_overlay <= 1'b0;
      o_brightness_apply <= 1'b1;
      o_force_black <= 1'b0;
      o_force_reference <= 1'b0;
      o_line_blank_pulse_insert <= 1'b0;
      o_power_save <= 1'b0;
    end else begin
      o_line_blank_pulse <= line_blank_c;
      o_frame_blank_pulse <= frame_blank_c;
      o_pixel_clk_en <= !line_blank_c && (pix_cnt_r == 8'h00);
      o_blue_channel_gain <= gain_r[0];
      o_green_channel_gain <= gain_r[1];
      o_red_channel_gain <= gain_r[2];
      o_overall_gain <= gain_r[3];
      o_blue_clamp_level <= clamp_r[0];
      o_green_clamp_level <= clamp_r[1];
      o_red_clamp_level <= clamp_r[2];
      o_brightness_level <= clamp_r[3];
      o_pedestal <= shared_r[`PEDESTAL_MSB:`PEDESTAL_LSB];
      o_overlay_gain <= shared_r[`OVERLAY_GAIN_MSB:`OVERLAY_GAIN_LSB];
      o_video_level_shift <= shared_r[`LEVEL_SHIFT_MSB:`LEVEL_SHIFT_LSB];
      o_use_overlay <= i_overlay_source_select;
      o_brightness_apply <= ~i_overlay_source_select;
      o_force_black <= line_lost_r | frame_lost_r |
                       (power_r == `PWR_BLANK) | (power_r == `PWR_SAVE);
      o_force_reference <= i_supply_low_threshold;
      o_line_blank_pulse_insert <= line_blank_c;
      o_power_save <= (power_r == `PWR_SAVE);
    end
  end
endmodule
`default_nettype wire

// ---- include/preamp_ctrl_consts.vh ----
/*
  Register offsets, field positions, reset values and timing counts
  for the video pre-amp control bank. Definitions only.
*/
`ifndef PREAMP_CTRL_CONSTS_VH
`define PREAMP_CTRL_CONSTS_VH
`define DEV_ADDR_7 7'h5D
`define OFS_BLUE_GAIN 16'h8430
`define OFS_GREEN_GAIN 16'h8431
`define OFS_RED_GAIN 16'h8432
`define OFS_OVERALL_GAIN 16'h8433
`define OFS_BLUE_CLAMP 16'h8434
`define OFS_GREEN_CLAMP 16'h8435
`define OFS_RED_CLAMP 16'h8436
`define OFS_BRIGHTNESS 16'h8437
`define OFS_SHARED_CTRL 16'h8438
`define OFS_POWER_CTRL 16'h8439
`define OFS_PIXEL_DIV 16'h843A
`define OFS_STATUS 16'h843B
`define RST_GAIN 7'h60
`define RST_CLAMP 8'h80
`define RST_PEDESTAL 3'h4
`define RST_OVERLAY_GAIN 2'h2
`define RST_LEVEL_SHIFT 3'h4
`define RST_SHARED_CTRL 8'h94
`define RST_POWER_CTRL 8'h00
`define RST_PIXEL_DIV 8'h10
`define PEDESTAL_MSB 7
`define PEDESTAL_LSB 5
`define OVERLAY_GAIN_MSB 4
`define OVERLAY_GAIN_LSB 3
`define LEVEL_SHIFT_MSB 2
`define LEVEL_SHIFT_LSB 0
`define PWR_BLANK 8'h01
`define PWR_SAVE 8'h02
`define LINE_TIMEOUT 16'h0800
`define FRAME_TIMEOUT 24'h10_0000
`define FREE_LINE_PERIOD 16'h0500
`endif

// ---- hdl/preamp_serial_slave.v ----
/*
  Two-wire serial slave: address byte, 16-bit register index, data.
  Assumes SCL and SDA already synchronous to i_mclk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "preamp_ctrl_consts.vh"
module preamp_serial_slave (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // Serial pins
  input wire i_scl,
  input wire i_sda,
  output reg o_sda_oe,
  // Register port
  output reg [15:0] o_addr,
  output reg [7:0] o_wdata,
  output reg o_wr,
  output reg o_rd,
  input wire [7:0] i_rdata
);
  localparam ST_IDLE = 3'd0;
  localparam ST_DEV = 3'd1;
  localparam ST_IDXH = 3'd2;
  localparam ST_IDXL = 3'd3;
  localparam ST_WDATA = 3'd4;
  localparam ST_RDATA = 3'd5;
  localparam ST_SKIP = 3'd6;
  reg scl_d_r;
  reg sda_d_r;
  reg [2:0] state_r;
  reg [2:0] after_ack_r;
  reg [3:0] bitcnt_r;
  reg [7:0] shift_r;
  reg ack_phase_r;
  reg read_mode_r;
  wire scl_rise;
  wire scl_fall;
  wire start_c;
  wire stop_c;
  assign scl_rise = i_scl & ~scl_d_r;
  assign scl_fall = ~i_scl & scl_d_r;
  assign start_c = i_scl & scl_d_r & sda_d_r & ~i_sda;
  assign stop_c = i_scl & scl_d_r & ~sda_d_r & i_sda;
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      state_r <= ST_IDLE;
      after_ack_r <= ST_IDLE;
      bitcnt_r <= 4'd0;
      shift_r <= 8'h00;
      ack_phase_r <= 1'b0;
      read_mode_r <= 1'b0;
      o_sda_oe <= 1'b0;
      o_addr <= 16'h0000;
      o_wdata <= 8'h00;
      o_wr <= 1'b0;
      o_rd <= 1'b0;
    end else begin
      scl_d_r <= i_scl;
      sda_d_r <= i_sda;
      o_wr <= 1'b0;
      o_rd <= 1'b0;
      if (start_c) begin
        state_r <= ST_DEV;
        bitcnt_r <= 4'd0;
        ack_phase_r <= 1'b0;
        o_sda_oe <= 1'b0;
      end else if (stop_c) begin
        state_r <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end else if (state_r != ST_IDLE && state_r != ST_SKIP) begin
        if (scl_rise && !ack_phase_r) begin
          if (state_r == ST_RDATA) begin
            if (bitcnt_r == 4'd8) begin
              read_mode_r <= ~i_sda;
            end
          end else begin
            shift_r <= {shift_r[6:0], i_sda};
            bitcnt_r <= bitcnt_r + 4'd1;
          end
        end
        if (scl_fall) begin
          if (ack_phase_r) begin
            ack_phase_r <= 1'b0;
            o_sda_oe <= 1'b0;
            state_r <= after_ack_r;
            bitcnt_r <= 4'd0;
            if (after_ack_r == ST_RDATA) begin
              shift_r <= i_rdata;
              o_sda_oe <= ~i_rdata[7];
            end
          end else if (state_r == ST_RDATA) begin
            if (bitcnt_r == 4'd8) begin
              o_sda_oe <= 1'b0;
              state_r <= read_mode_r ? ST_RDATA : ST_SKIP;
              bitcnt_r <= 4'd0;
              if (read_mode_r) begin
                shift_r <= i_rdata;
                o_sda_oe <= ~i_rdata[7];
                o_rd <= 1'b1;
              end
            end else begin
              bitcnt_r <= bitcnt_r + 4'd1;
              shift_r <= {shift_r[6:0], 1'b0};
              o_sda_oe <= (bitcnt_r == 4'd7) ? 1'b0 : ~shift_r[6];
              if (bitcnt_r == 4'd7) begin
                o_addr <= o_addr + 16'h0001;
              end
            end
          end else if (bitcnt_r == 4'd8) begin
            ack_phase_r <= 1'b1;
            o_sda_oe <= 1'b1;
            case (state_r)
              ST_DEV: begin
                if (shift_r[7:1] == `DEV_ADDR_7) begin
                  after_ack_r <= shift_r[0] ? ST_RDATA : ST_IDXH;
                  if (shift_r[0]) begin
                    o_rd <= 1'b1;
                  end
                end else begin
                  ack_phase_r <= 1'b0;
                  o_sda_oe <= 1'b0;
                  state_r <= ST_SKIP;
                end
              end
              ST_IDXH: begin
                o_addr[15:8] <= shift_r;
                after_ack_r <= ST_IDXL;
              end
              ST_IDXL: begin
                o_addr[7:0] <= shift_r;
                after_ack_r <= ST_WDATA;
              end
              ST_WDATA: begin
                o_wdata <= shift_r;
                o_wr <= 1'b1;
                after_ack_r <= ST_WDATA;
              end
              default: begin
                after_ack_r <= ST_IDLE;
              end
            endcase
          end
        end
      end
      if (o_wr) begin
        o_addr <= o_addr + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/preamp_ctrl_regs_checker.sv ----
/* Assertions on the pre-amp control bank ports.
   Assumes one clock; bound below. */
`timescale 1ns/1ns
`default_nettype none
module preamp_ctrl_regs_checker #(
  parameter LINE_TIMEOUT = 64,
  parameter FRAME_TIMEOUT = 512,
  parameter FREE_LINE_PERIOD = 32
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Inputs
  input wire logic i_line_retrace,
  input wire logic i_vertical_retrace_pulse,
  input wire logic i_supply_low_threshold,
  input wire logic i_overlay_source_select,
  // Outputs
  input wire logic o_line_blank_pulse,
  input wire logic o_pixel_clk_en,
  input wire logic o_use_overlay,
  input wire logic o_brightness_apply,
  input wire logic o_force_black,
  input wire logic o_force_reference,
  input wire logic o_line_blank_pulse_insert,
  input wire logic o_power_save
);
  logic [15:0] line_low_r;
  logic [23:0] frame_low_r;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////
  // Cycles since each retrace input was high
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      line_low_r <= 16'h0000;
      frame_low_r <= 24'h00_0000;
    end else begin
      line_low_r <= i_line_retrace ? 16'h0000 : line_low_r + {15'h0000, ~&line_low_r};
      frame_low_r <= i_vertical_retrace_pulse ? 24'h00_0000 : frame_low_r + {23'h00_0000, ~&frame_low_r};
    end
  end
  ////////////////////////////////
  property p_sel;
    i_overlay_source_select |=> o_use_overlay;
  endproperty
  a_sel: assert property (p_sel) else $error("overlay select not taken");
  property p_bri;
    o_brightness_apply == !$past(i_overlay_source_select);
  endproperty
  a_bri: assert property (p_bri) else $error("brightness applied to overlay");
  property p_hbl;
    $past(i_rst_n) && $past(i_line_retrace) && !o_force_black |-> o_line_blank_pulse_insert;
  endproperty
  a_hbl: assert property (p_hbl) else $error("blanking not inserted");
  property p_line_pass;
    !o_force_black && i_line_retrace |=> o_line_blank_pulse;
  endproperty
  a_line_pass: assert property (p_line_pass) else $error("line blank not passed");
  property p_line_lost;
    line_low_r == LINE_TIMEOUT + 4 |-> o_force_black;
  endproperty
  a_line_lost: assert property (p_line_lost) else $error("line loss not blacked");
  property p_frame_lost;
    frame_low_r == FRAME_TIMEOUT + 4 |-> o_force_black;
  endproperty
  a_frame_lost: assert property (p_frame_lost) else $error("frame loss not blacked");
  property p_supply;
    i_supply_low_threshold |-> ##[1:2] o_force_reference;
  endproperty
  a_supply: assert property (p_supply) else $error("supply low ignored");
  property p_save;
    o_power_save |-> o_force_black;
  endproperty
  a_save: assert property (p_save) else $error("power save not black");
  property p_pix;
    o_pixel_clk_en |=> !o_pixel_clk_en;
  endproperty
  a_pix: assert property (p_pix) else $error("pixel enable too long");
endmodule
bind preamp_ctrl_regs preamp_ctrl_regs_checker #(
  .LINE_TIMEOUT(LINE_TIMEOUT),
  .FRAME_TIMEOUT(FRAME_TIMEOUT),
  .FREE_LINE_PERIOD(FREE_LINE_PERIOD)
) chk_i (
  .i_mclk, .i_rst_n, .i_line_retrace, .i_vertical_retrace_pulse, .i_supply_low_threshold,
  .i_overlay_source_select, .o_line_blank_pulse, .o_pixel_clk_en, .o_use_overlay,
  .o_brightness_apply, .o_force_black, .o_force_reference, .o_line_blank_pulse_insert, .o_power_save
);
`default_nettype wire

// ---- test/serial_host_model.sv ----
/* Two-wire serial master standing in for the monitor controller.
   Assumes open-drain SDA with pull-up; only this model drives SCL. */
`timescale 1ns/1ns
`default_nettype none
`include "preamp_ctrl_consts.vh"
module serial_host_model (
  // Clock
  input wire logic i_mclk,
  // Serial bus
  input wire logic i_sda_oe,
  output logic o_scl,
  output logic o_sda
);
  logic sda_drv = 1'b1;
  initial o_scl = 1'b1;
  // Wired-AND with pull-up
  assign o_sda = sda_drv & ~i_sda_oe;
  ////////////////////////////////
  // SCL low and high four cycles each
  task automatic bit_io(input logic b, output logic r);
    o_scl <= 1'b0;
    repeat (2) @(posedge i_mclk);
    sda_drv <= b;
    repeat (2) @(posedge i_mclk);
    o_scl <= 1'b1;
    repeat (2) @(posedge i_mclk);
    r = o_sda;
    repeat (2) @(posedge i_mclk);
  endtask
  // Start when stop is low, else stop
  task automatic cond(input logic stop);
    o_scl <= 1'b0;
    repeat (2) @(posedge i_mclk);
    sda_drv <= ~stop;
    repeat (2) @(posedge i_mclk);
    o_scl <= 1'b1;
    repeat (3) @(posedge i_mclk);
    sda_drv <= stop;
    repeat (3) @(posedge i_mclk);
  endtask
  task automatic byte_io(input logic [7:0] d, input logic m_ack, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(m_ack, r);
    ack = ~r;
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [15:0] idx, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2, a3;
    @(posedge i_mclk);
    cond(1'b0);
    byte_io({dev, 1'b0}, 1'b1, q, a0);
    byte_io(idx[15:8], 1'b1, q, a1);
    byte_io(idx[7:0], 1'b1, q, a2);
    byte_io(d, 1'b1, q, a3);
    cond(1'b1);
    ok = a0 & a1 & a2 & a3;
  endtask
  task automatic read_reg(input logic [15:0] idx, output logic [7:0] d);
    logic [7:0] q;
    logic a;
    @(posedge i_mclk);
    cond(1'b0);
    byte_io({`DEV_ADDR_7, 1'b0}, 1'b1, q, a);
    byte_io(idx[15:8], 1'b1, q, a);
    byte_io(idx[7:0], 1'b1, q, a);
    cond(1'b0);
    byte_io({`DEV_ADDR_7, 1'b1}, 1'b1, q, a);
    byte_io(8'hFF, 1'b1, d, a);
    cond(1'b1);
  endtask
endmodule
`default_nettype wire

// ---- test/tb_crt_preamp_control_regs.sv ----
/* Self-checking bench for the pre-amp control bank.
   Assumes the serial host model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
`include "preamp_ctrl_consts.vh"
module tb_crt_preamp_control_regs;
  localparam int LT = 64;
  localparam int FT = 512;
  localparam int FL = 32;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_line_retrace = 1'b0;
  logic i_vertical_retrace_pulse = 1'b0;
  logic i_supply_low_threshold = 1'b0;
  logic i_overlay_source_select = 1'b0;
  wire logic i_scl, i_sda, o_sda_out, o_sda_oe, o_line_blank_pulse, o_frame_blank_pulse, o_pixel_clk_en;
  wire logic [6:0] o_blue_channel_gain, o_green_channel_gain, o_red_channel_gain, o_overall_gain;
  wire logic [7:0] o_blue_clamp_level, o_green_clamp_level, o_red_clamp_level, o_brightness_level;
  wire logic [2:0] o_pedestal, o_video_level_shift;
  wire logic [1:0] o_overlay_gain;
  wire logic o_use_overlay, o_brightness_apply, o_force_black, o_force_reference, o_line_blank_pulse_insert, o_power_save;
  int err_count = 0;
  int total_checks = 0;
  int seed = 71300;
  int n, t0, k;
  string nq[$];
  logic [7:0] eq[$];
  logic [7:0] obs_v, d, v, e;
  logic [7:0] exp_r [0:8];
  logic ok, p, q;
  logic [5:0] lc = 6'h00;
  logic [2:0] fc = 3'h0;
  logic fld = 1'b0, line_on = 1'b1, frame_on = 1'b1;
  event got;
  always #25 i_mclk = ~i_mclk;
  preamp_ctrl_regs #(.LINE_TIMEOUT(LT), .FRAME_TIMEOUT(FT), .FREE_LINE_PERIOD(FL)) dut (
    .i_mclk, .i_rst_n, .i_scl, .i_sda, .o_sda_out, .o_sda_oe,
    .i_line_retrace, .i_vertical_retrace_pulse, .i_supply_low_threshold, .i_overlay_source_select,
    .o_line_blank_pulse, .o_frame_blank_pulse, .o_pixel_clk_en,
    .o_blue_channel_gain, .o_green_channel_gain, .o_red_channel_gain, .o_overall_gain,
    .o_blue_clamp_level, .o_green_clamp_level, .o_red_clamp_level, .o_brightness_level,
    .o_pedestal, .o_overlay_gain, .o_video_level_shift, .o_use_overlay,
    .o_brightness_apply, .o_force_black, .o_force_reference, .o_line_blank_pulse_insert, .o_power_save
  );
  serial_host_model host (.i_mclk, .i_sda_oe(o_sda_oe & ~o_sda_out), .o_scl(i_scl), .o_sda(i_sda));
  ////////////////////////////////
  // Scan timing with half-line interlace shift
  always @(posedge i_mclk) begin
    lc <= (lc == 6'd39) ? 6'd0 : lc + 6'd1;
    if (lc == 6'd39) fc <= fc + 3'd1;
    if (lc == 6'd39 && fc == 3'd7) fld <= ~fld;
    i_line_retrace <= line_on && lc < 6'd4;
    i_vertical_retrace_pulse <= frame_on && fc == 3'd0 && lc >= (fld ? 6'd20 : 6'd0) && lc < (fld ? 6'd24 : 6'd4);
  end
  always @(got) begin
    total_checks++;
    if (obs_v !== eq[0]) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nq[0], eq[0], obs_v);
    end
    void'(eq.pop_front());
    void'(nq.pop_front());
  end
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] ob);
    nq.push_back(nm);
    eq.push_back(ex);
    obs_v = ob;
    -> got;
    #1;
  endtask
  function automatic logic [7:0] port_of(input int i);
    case (i)
      0: return {1'b0, o_blue_channel_gain};
      1: return {1'b0, o_green_channel_gain};
      2: return {1'b0, o_red_channel_gain};
      4: return o_blue_clamp_level;
      5: return o_green_clamp_level;
      6: return o_red_clamp_level;
      7: return o_brightness_level;
      8: return {o_pedestal, o_overlay_gain, o_video_level_shift};
      default: return {1'b0, o_overall_gain};
    endcase
  endfunction
  function automatic logic [7:0] rst_of(input int i);
    return (i < 4) ? 8'h60 : (i < 8) ? 8'h80 : {3'h4, 2'h2, 3'h4};
  endfunction
  // Retrace loss: black forced, blank pulses kept, recovery
  task automatic loss(input logic line, input int w);
    @(posedge i_mclk);
    if (line) line_on <= 1'b0;
    else frame_on <= 1'b0;
    repeat (w) @(posedge i_mclk);
    chk("lost_black", 8'h01, {7'h00, o_force_black});
    n = 0;
    q = 1'b1;
    repeat (w) begin
      @(posedge i_mclk);
      p = line ? o_line_blank_pulse : o_frame_blank_pulse;
      if (p && !q) n++;
      q = p;
    end
    chk("lost_pulses", 8'h01, {7'h00, n > 0});
    line_on <= 1'b1;
    frame_on <= 1'b1;
    repeat (w) @(posedge i_mclk);
    chk("restored", 8'h00, {7'h00, o_force_black});
    $display("test loss done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge i_mclk);
    err_count++;
    $display("watchdog expired");
    end_sim();
  end
  ////////////////////////////////
  initial begin
    repeat (20) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (2000) @(posedge i_mclk);
    chk("interlace_black", 8'h00, {7'h00, o_force_black});
    for (int i = 0; i < 9; i++) begin
      chk("reset_port", rst_of(i), port_of(i));
      host.read_reg(`OFS_BLUE_GAIN + i[15:0], d);
      chk("reset_read", rst_of(i), d);
    end
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      v = $random(seed);
      e = (i < 4) ? {1'b0, v[6:0]} : v;
      exp_r[i] = e;
      host.write_reg(`DEV_ADDR_7, `OFS_BLUE_GAIN + i[15:0], v, ok);
      chk("write_ack", 8'h01, {7'h00, ok});
      chk("reg_port", e, port_of(i));
      host.read_reg(`OFS_BLUE_GAIN + i[15:0], d);
      chk("reg_read", e, d);
    end
    host.write_reg(`DEV_ADDR_7 ^ 7'h01, `OFS_OVERALL_GAIN, ~exp_r[3], ok);
    chk("foreign_ack", 8'h00, {7'h00, ok});
    chk("foreign_keep", exp_r[3], port_of(3));
    host.read_reg(16'h8450, d);
    chk("unmapped_read", 8'h00, d);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      @(posedge i_mclk);
      v = $random(seed);
      i_overlay_source_select <= v[0];
      @(posedge i_mclk);
      @(negedge i_mclk);
      chk("overlay_sel", {6'h00, ~v[0], v[0]}, {6'h00, o_brightness_apply, o_use_overlay});
    end
    i_supply_low_threshold <= 1'b1;
    repeat (3) @(posedge i_mclk);
    chk("supply_low", 8'h01, {7'h00, o_force_reference});
    i_supply_low_threshold <= 1'b0;
    repeat (3) @(posedge i_mclk);
    chk("supply_ok", 8'h00, {7'h00, o_force_reference});
    $display("test overlay and supply done");
    for (int i = 4; i < 8; i++)
      host.write_reg(`DEV_ADDR_7, `OFS_BLUE_GAIN + i[15:0], 8'h00, ok);
    chk("clamp_zero", 8'h00, port_of(7));
    host.write_reg(`DEV_ADDR_7, `OFS_POWER_CTRL, 8'h01, ok);
    chk("blank", 8'h01, {6'h00, o_power_save, o_force_black});
    host.write_reg(`DEV_ADDR_7, `OFS_POWER_CTRL, 8'h02, ok);
    chk("save", 8'h03, {6'h00, o_power_save, o_force_black});
    host.read_reg(`OFS_POWER_CTRL, d);
    chk("save_read", 8'h02, d);
    host.write_reg(`DEV_ADDR_7, `OFS_POWER_CTRL, 8'h00, ok);
    chk("awake", 8'h00, {6'h00, o_power_save, o_force_black});
    $display("test power done");
    host.write_reg(`DEV_ADDR_7, `OFS_PIXEL_DIV, 8'h04, ok);
    @(negedge o_line_blank_pulse);
    t0 = 0;
    k = 0;
    for (int c = 1; c < 30; c++) begin
      @(negedge i_mclk);
      if (o_pixel_clk_en === 1'b1 && t0 != 0 && k == 0) k = c - t0;
      if (o_pixel_clk_en === 1'b1 && t0 == 0) t0 = c;
    end
    chk("pixel_gap", 8'h04, k[7:0]);
    $display("test pixel clock done");
    loss(1'b1, LT + 2 * FL);
    loss(1'b0, 2 * FT + 20);
    end_sim();
  end
endmodule
`default_nettype wire
